/* File: bench/acr_channel_pipeline_tb.sv */
// Self-checking bench for the channel pipeline
`include "acr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module acr_channel_pipeline_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	acr_pkg::acr_pins_s pins = '0;
	acr_pkg::acr_ctl_s ctl;
	acr_pkg::acr_bus_s bus = '0;
	logic [31:0] rdData_q;
	logic [3:0] idx_q;
	logic run = 1'b0, integ = 1'b0, memClr = 1'b0, tickEn = 1'b0, rndA = 1'b0, rndB = 1'b0, pend = 1'b0;
	logic [63:0] q[$];
	logic [63:0] e;
	integer seed = 53;
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;
	always #2.5 clk = ~clk;
	acr_channel_pipeline dut (.clk(clk), .arst_n(arst_n), .pins(pins), .ctl(ctl), .bus(bus), .rdData_q(rdData_q));
	acr_ctl_model partner (.clk(clk), .arst_n(arst_n), .run(run), .integ(integ), .memClr(memClr), .tickEn(tickEn),
		.ctl(ctl), .idx_q(idx_q));
	task automatic conclude();
		if (n_mismatch == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH rdData expected %h seen %h", exp, seen);
		end
	endtask
	// Idle cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
		@(posedge clk);
		bus.wrEn <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		@(posedge clk);
		bus <= '{addr: a, wrData: 32'h0, wrEn: 1'b0, rdEn: 1'b1};
		q.push_back({m, x & m});
		@(posedge clk);
		bus.rdEn <= 1'b0;
	endtask
	task automatic rdc(input logic [8:0] ch, input logic [31:0] m, input logic [31:0] x);
		wr(`ACR_OFF_SEL, {23'h0, ch});
		rd(`ACR_OFF_DATA, m, x);
	endtask
	task automatic ticks(input int n);
		@(posedge clk);
		tickEn <= 1'b1;
		repeat (n * 20) @(posedge clk);
		tickEn <= 1'b0;
	endtask
	always @(posedge clk) begin
		if (pend) begin
			e = q.pop_front();
			check(rdData_q & e[63:32], e[31:0]);
		end
		pend <= bus.rdEn;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		pins.samplerC <= $random(seed);
		if (rndA)
			pins.samplerA <= $random(seed);
		if (rndB)
			pins.samplerB <= $random(seed);
		if (cycles == 90000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		rd(`ACR_OFF_CTRL, 32'hFFFFFFFF, 32'h3);
		rd(8'h10, 32'hFFFFFFFF, 32'h0);
		wr(8'h10, 32'hFFFFFFFF);
		wr(`ACR_OFF_DATA, 32'hFFFF);
		rd(`ACR_OFF_CTRL, 32'hFFFFFFFF, 32'h3);
		rdc(9'h000, 32'hFFFFFFFF, 32'h0);
		rd(`ACR_OFF_STATUS, 32'h1F7, 32'h0);
		pins.samplerA <= 1'b1;
		pins.samplerB <= 1'b1;
		// Lags fill while blanked
		ticks(300);
		integ <= 1'b1;
		ticks(64);
		for (int i = 0; i < 4; i++)
			rdc(9'(i < 2 ? i * 207 : 208 + (i - 2) * 204), 32'h1FF00, 32'h4000);
		integ <= 1'b0;
		rdc(9'h000, 32'h1FF00, 32'h0);
		wr(`ACR_OFF_CTRL, 32'h1);
		rndA <= 1'b1;
		// Old live ones still sit in the first two stages; flush them while blanked
		ticks(2);
		integ <= 1'b1;
		ticks(64);
		rd(`ACR_OFF_STATUS, 32'h200, 32'h0);
		rdc(9'h064, 32'h1FF00, 32'h0);
		rdc(9'h0CF, 32'h1FF00, 32'h0);
		rdc(9'h12C, 32'h1FF00, 32'h4000);
		integ <= 1'b0;
		wr(`ACR_OFF_CTRL, 32'h4);
		rndB <= 1'b1;
		ticks(450);
		integ <= 1'b1;
		ticks(64);
		rd(`ACR_OFF_STATUS, 32'h200, 32'h200);
		for (int i = 0; i < 3; i++)
			rdc(9'(i * 206), 32'h1FF00, 32'h4000);
		for (int k = 0; k < 5; k++) begin
			pins.vfPulse <= (k < 2) ? 3'h3 : 3'h1;
			repeat (4) @(posedge clk);
			pins.vfPulse <= 3'h0;
			repeat (4) @(posedge clk);
		end
		rdc(9'h19D, 32'h1FF00, 32'h500);
		rdc(9'h19E, 32'h1FF00, 32'h200);
		rdc(9'h19F, 32'h1FF00, 32'h0);
		integ <= 1'b0;
		rndA <= 1'b0;
		rndB <= 1'b0;
		pins.samplerA <= 1'b1;
		pins.samplerB <= 1'b1;
		wr(`ACR_OFF_CTRL, 32'h3);
		wr(`ACR_OFF_STATUS, 32'h7);
		memClr <= 1'b1;
		rd(`ACR_OFF_STATUS, 32'hF0, 32'h0);
		rdc(9'h005, 32'hFF, 32'h0);
		memClr <= 1'b0;
		ticks(300);
		integ <= 1'b1;
		run <= 1'b1;
		// Ninth bit changes every 5120 cycles, each channel served every 2400
		ticks(600);
		repeat (7200) @(posedge clk);
		run <= 1'b0;
		repeat (200) @(posedge clk);
		rd(`ACR_OFF_STATUS, 32'h1F7, {23'h1, idx_q, 4'h0});
		for (int i = 0; i < 3; i++)
			rdc(9'(i * 15 + (i / 2) * 255), 32'h1FFFF, 32'h5802);
		// Rounds stopped while still integrating, so the watchdog must trip
		repeat (2600) @(posedge clk);
		rd(`ACR_OFF_STATUS, 32'h7, 32'h4);
		integ <= 1'b0;
		wr(`ACR_OFF_STATUS, 32'h7);
		rd(`ACR_OFF_STATUS, 32'h7, 32'h0);
		conclude();
	end
endmodule // acr_channel_pipeline_tb
`default_nettype wire

/* File: bench/acr_ctl_model.sv */
// Control timing unit model: sample ticks, blanking and 750 ns memory slots
`timescale 1ns/10ps
`default_nettype none
module acr_ctl_model (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Bench requests
	input wire logic run,
	input wire logic integ,
	input wire logic memClr,
	input wire logic tickEn,
	// Strobes and slot index
	output var acr_pkg::acr_ctl_s ctl,
	output logic [3:0] idx_q
);
	logic [7:0] slot_q;
	logic [4:0] tick_q;
	logic act_q;
	wire logic slotEnd = !act_q || slot_q == 8'h95;
	function automatic logic win(input logic [7:0] lo, input logic [7:0] hi);
		return act_q && slot_q >= lo && slot_q < hi;
	endfunction
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			slot_q <= 8'h00;
			tick_q <= 5'h00;
			act_q <= 1'b0;
			idx_q <= 4'h0;
		end else begin
			tick_q <= (tick_q == 5'h13) ? 5'h00 : tick_q + 5'h01;
			slot_q <= slotEnd ? 8'h00 : slot_q + 8'h01;
			// Stops only at a slot boundary so no strobe is cut short
			if (slotEnd)
				act_q <= run;
			if (memClr && !integ)
				idx_q <= 4'h0;
			else if (act_q && slot_q == 8'h86)
				idx_q <= idx_q + 4'h1;
		end
	end
	always_comb begin
		ctl.sampleTick = tickEn && tick_q == 5'h13;
		ctl.integrateNotBlank = integ;
		ctl.memoryClearCtl = memClr;
		ctl.outLatchClear_n = !win(8'h00, 8'h14);
		ctl.channelSelect = win(8'h14, 8'h46) ? 16'h0001 << idx_q : 16'h0000;
		ctl.resetGuard_n = !win(8'h44, 8'h5C);
		ctl.loadStrobeA_n = !win(8'h46, 8'h5A);
		ctl.loadStrobeB_n = !win(8'h48, 8'h58);
		ctl.countStrobe = win(8'h5C, 8'h70);
		ctl.storeShiftStrobe = win(8'h73, 8'h87);
	end
endmodule // acr_ctl_model
`default_nettype wire

/* File: bench/acr_pipe_props.sv */
// Port assertions for the channel pipeline
`include "acr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module acr_pipe_props (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Watched ports
	input wire acr_pkg::acr_pins_s pins,
	input wire acr_pkg::acr_ctl_s ctl,
	input wire acr_pkg::acr_bus_s bus,
	input wire logic [31:0] rdData_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	wire logic rdD = bus.rdEn && bus.addr == `ACR_OFF_DATA;
	wire logic rdS = bus.rdEn && bus.addr == `ACR_OFF_STATUS;
	wire logic clr = ctl.memoryClearCtl && !ctl.integrateNotBlank;
	wire logic mapped = bus.addr[7:4] == 4'h0 && bus.addr[1:0] == 2'h0;
	a_idle_read_zero: assert property (!$past(bus.rdEn) |-> rdData_q == 32'h0)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (bus.rdEn && !mapped |=> rdData_q == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_upper_zero: assert property (bus.rdEn && bus.addr == `ACR_OFF_CTRL |=> rdData_q[31:3] == 29'h0)
		else $error("control read has upper bits");
	a_data_upper_zero: assert property (rdD |=> rdData_q[31:17] == 15'h0)
		else $error("data read has upper bits");
	a_blank_cnt_zero: assert property (!ctl.integrateNotBlank [*2] ##0 rdD |=> rdData_q[16:8] == 9'h0)
		else $error("counter not cleared in blanking");
	a_integ_status: assert property (rdS && $stable(ctl.integrateNotBlank) |=> rdData_q[8] == $past(ctl.integrateNotBlank))
		else $error("integrate status wrong");
	a_clear_total_zero: assert property (clr ##1 (clr && rdD) |=> rdData_q[7:0] == 8'h0)
		else $error("stored total not cleared");
	a_clear_idx_zero: assert property (clr ##1 (clr && rdS) |=> rdData_q[7:4] == 4'h0)
		else $error("channel index not cleared");
	c_count_seen: cover property (rdD ##1 rdData_q[16:8] != 9'h0);
	c_total_seen: cover property (rdD ##1 rdData_q[7:0] != 8'h0);
	c_store_seen: cover property ($rose(ctl.storeShiftStrobe));
endmodule // acr_pipe_props
bind acr_channel_pipeline acr_pipe_props u_props (.clk(clk), .arst_n(arst_n), .pins(pins), .ctl(ctl), .bus(bus),
	.rdData_q(rdData_q));
`default_nettype wire

/* File: design/acr_channel_pipeline.sv */
// One-bit autocorrelator datapath: delay chain, lag channels, counters, shift memories
//
// Summary of operation
// - Three-stage delay; multiplier middle, lag last
// - Serial mode feeds both paths from A
// - Test select swaps A, C for level
// - 416 channels in 26 groups of 16
// - Multiplier is XNOR of present, delayed sample
// - Counter carry from complement; blanking clears counters
// - Multiplier gated by blanking; lag keeps shifting
// - Seven more stages per channel, cleared in blanking
// - One-hot select gates group's ninth bit out
// - Latch clear low 100ns before select
// - Select high 250ns latches ninth bit
// - Last three channels count converter pulses
// - Ninth stage doubles as accumulator first stage
// - Shared counter, 750ns slot, 12us cycle
// - Service interval beats 12.8us ninth-bit period
// - Both load strobes low loads stored total
// - Count strobe 100ns clocks latched bit in
// - Store strobe 100ns shifts updated total in
//
// Design decisions made here: the placing of the registers and strobed register access.
`include "acr_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module acr_channel_pipeline (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Pins from samplers and converters
	input wire acr_pkg::acr_pins_s pins,
	// Control unit strobes, same clock
	input wire acr_pkg::acr_ctl_s ctl,
	// Register port
	input wire acr_pkg::acr_bus_s bus,
	output logic [31:0] rdData_q
);

	localparam int NCH = `ACR_CHANNELS;
	localparam int NGR = `ACR_GROUPS;
	localparam int GSZ = `ACR_GROUP_SIZE;

	// Pin synchronisers: first stage feeds only the second
	logic [5:0] pinMeta_q;
	logic [5:0] pinSync_q;
	logic [5:0] pinRaw;
	assign pinRaw = {pins.vfPulse, pins.samplerC, pins.samplerB, pins.samplerA};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pinMeta_q <= 6'h00;
			pinSync_q <= 6'h00;
		end else begin
			pinMeta_q <= pinRaw;
			pinSync_q <= pinMeta_q;
		end
	end

	// Software control
	logic [2:0] ctrl_q;
	wire serialSelect = ctrl_q[`ACR_CTRL_SERIAL];
	wire testInputSelect = ctrl_q[`ACR_CTRL_TESTSEL];
	wire testLevel = ctrl_q[`ACR_CTRL_TESTLVL];

	// Clock gating as enables: lag path always runs, multiplier stops in blanking
	wire integrating = ctl.integrateNotBlank;
	wire shiftEn = ctl.sampleTick;
	wire multEn = ctl.sampleTick & integrating;

	// Receiver inputs; B has no test path
	wire inA = testInputSelect ? pinSync_q[0] : testLevel;
	wire inC = testInputSelect ? pinSync_q[2] : testLevel;
	wire serialMode = ~serialSelect;
	wire inB = serialMode ? inA : pinSync_q[1];

	// Delay chains, index 0 first, 1 middle, 2 last
	logic [2:0] sampleDelayA_q;
	logic [2:0] sampleDelayB_q;
	logic [2:0] sampleDelayC_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sampleDelayA_q <= 3'h0;
			sampleDelayB_q <= 3'h0;
			sampleDelayC_q <= 3'h0;
		end else if (shiftEn) begin
			sampleDelayA_q <= {sampleDelayA_q[1:0], inA};
			sampleDelayB_q <= {sampleDelayB_q[1:0], inB};
			sampleDelayC_q <= {sampleDelayC_q[1:0], inC};
		end
	end

	wire presentA = sampleDelayA_q[1];
	wire presentB = sampleDelayB_q[1];

	// Lag shift register; in serial mode the second half continues the first
	logic [NCH-1:0] lag_q;
	wire secondHalfIn = serialMode ? lag_q[`ACR_HALF-1] : sampleDelayB_q[2];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lag_q <= '0;
		end else if (shiftEn) begin
			lag_q[0] <= sampleDelayA_q[2];
			lag_q[`ACR_HALF-1:1] <= lag_q[`ACR_HALF-2:0];
			lag_q[`ACR_HALF] <= secondHalfIn;
			lag_q[NCH-1:`ACR_HALF+1] <= lag_q[NCH-2:`ACR_HALF];
		end
	end

	// Converter pulse edges for the power channels
	logic [2:0] vfPrev_q;
	wire [2:0] vfRise = pinSync_q[5:3] & ~vfPrev_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			vfPrev_q <= 3'h0;
		end else begin
			vfPrev_q <= pinSync_q[5:3];
		end
	end

	// Per-channel counters: two correlator stages plus seven counter-card stages.
	// Set-only flip-flops with complement carry behave as a plain binary count.
	logic [`ACR_CNT_W-1:0] cnt_q [NCH];
	logic [NCH-1:0] countUp;

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : gChan
			if (gi >= `ACR_VF_FIRST) begin : gPower
				assign countUp[gi] = integrating & vfRise[gi-`ACR_VF_FIRST];
			end else begin : gCorr
				wire present = (gi < `ACR_HALF) ? presentA : (serialMode ? presentA : presentB);
				wire match = ~(present ^ lag_q[gi]);
				assign countUp[gi] = multEn & match;
			end
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					cnt_q[gi] <= '0;
				end else if (!integrating) begin
					cnt_q[gi] <= '0;
				end else if (countUp[gi]) begin
					cnt_q[gi] <= cnt_q[gi] + 9'h001;
				end
			end
		end
	endgenerate

	// Strobe edges from the control unit
	logic countPrev_q;
	logic storePrev_q;
	logic selAnyPrev_q;
	wire selAny = |ctl.channelSelect;
	wire countRise = ctl.countStrobe & ~countPrev_q;
	wire storeRise = ctl.storeShiftStrobe & ~storePrev_q;
	wire selRise = selAny & ~selAnyPrev_q;
	wire loadBoth = ~ctl.loadStrobeA_n & ~ctl.loadStrobeB_n;
	wire memClear = ctl.memoryClearCtl & ~integrating;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			countPrev_q <= 1'b0;
			storePrev_q <= 1'b0;
			selAnyPrev_q <= 1'b0;
		end else begin
			countPrev_q <= ctl.countStrobe;
			storePrev_q <= ctl.storeShiftStrobe;
			selAnyPrev_q <= selAny;
		end
	end

	// Channel index shared by all memory groups, one step per store slot
	logic [3:0] chanIdx_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			chanIdx_q <= 4'h0;
		end else if (memClear) begin
			chanIdx_q <= 4'h0;
		end else if (storeRise) begin
			chanIdx_q <= chanIdx_q + 4'h1;
		end
	end

	// Group ninth-bit gating, output latch, shared counter and storage
	logic [NGR-1:0] selBit;
	logic [NGR-1:0] outLatch_q;
	logic [`ACR_ACC_W-1:0] acc_q [NGR];
	logic [`ACR_ACC_W-1:0] mem_q [NGR][GSZ];

	generate
		for (gi = 0; gi < NGR; gi++) begin : gGroup
			logic [GSZ-1:0] ninth;
			genvar ci;
			for (ci = 0; ci < GSZ; ci++) begin : gTap
				assign ninth[ci] = cnt_q[gi*GSZ+ci][`ACR_CNT_W-1];
			end
			assign selBit[gi] = |(ninth & ctl.channelSelect);

			// Latch: cleared by low clear strobe, set while select is high
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					outLatch_q[gi] <= 1'b0;
				end else if (!ctl.outLatchClear_n) begin
					outLatch_q[gi] <= 1'b0;
				end else if (selAny) begin
					outLatch_q[gi] <= selBit[gi];
				end
			end

			// Latched bit drives the first stage true to J, complement to K; a 1 to 0 step carries
			wire carry = acc_q[gi][0] & ~outLatch_q[gi];
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					acc_q[gi] <= '0;
				end else if (memClear) begin
					acc_q[gi] <= '0;
				end else if (loadBoth) begin
					acc_q[gi] <= mem_q[gi][GSZ-1];
				end else if (countRise) begin
					acc_q[gi][0] <= outLatch_q[gi];
					acc_q[gi][`ACR_ACC_W-1:1] <= acc_q[gi][`ACR_ACC_W-1:1] + {6'h00, carry};
				end
			end

			// Circulating store: oldest total leaves the bottom, new enters the top
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					for (int k = 0; k < GSZ; k++) begin
						mem_q[gi][k] <= '0;
					end
				end else if (memClear) begin
					for (int k = 0; k < GSZ; k++) begin
						mem_q[gi][k] <= '0;
					end
				end else if (storeRise) begin
					mem_q[gi][0] <= acc_q[gi];
					for (int k = 1; k < GSZ; k++) begin
						mem_q[gi][k] <= mem_q[gi][k-1];
					end
				end
			end
		end
	endgenerate

	// Strobe width checks: clear low, select, count, store high
	localparam int NPW = 4;
	logic [NPW-1:0] pwLevel;
	logic [NPW-1:0] pwPrev_q;
	logic [`ACR_PW_W-1:0] pwCnt_q [NPW];
	logic [`ACR_PW_W-1:0] pwMin [NPW];
	logic [NPW-1:0] pwShort;
	assign pwLevel = {ctl.storeShiftStrobe, ctl.countStrobe, selAny, ~ctl.outLatchClear_n};
	assign pwMin[0] = `ACR_PW_W'(`ACR_CLEAR_CYC);
	assign pwMin[1] = `ACR_PW_W'(`ACR_SELECT_CYC);
	assign pwMin[2] = `ACR_PW_W'(`ACR_COUNT_CYC);
	assign pwMin[3] = `ACR_PW_W'(`ACR_STORE_CYC);

	generate
		for (gi = 0; gi < NPW; gi++) begin : gPw
			assign pwShort[gi] = pwPrev_q[gi] & ~pwLevel[gi] & (pwCnt_q[gi] < pwMin[gi]);
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					pwPrev_q[gi] <= 1'b0;
					pwCnt_q[gi] <= '0;
				end else begin
					pwPrev_q[gi] <= pwLevel[gi];
					if (!pwLevel[gi]) begin
						pwCnt_q[gi] <= '0;
					end else if (pwCnt_q[gi] != {`ACR_PW_W{1'b1}}) begin
						pwCnt_q[gi] <= pwCnt_q[gi] + 8'h01;
					end
				end
			end
		end
	endgenerate

	// Select must match the channel index the memory expects
	wire [15:0] expectSel = 16'h0001 << chanIdx_q;
	wire alignBad = selRise & (ctl.channelSelect != expectSel);

	// Service watchdog: a full 16-slot round must finish inside the ninth-bit period
	logic [`ACR_WDT_W-1:0] wdt_q;
	wire roundDone = storeRise & (chanIdx_q == 4'hF);
	wire overrun = integrating & (wdt_q == `ACR_WDT_W'(`ACR_SERVICE_CYC));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wdt_q <= '0;
		end else if (!integrating || roundDone) begin
			wdt_q <= '0;
		end else if (!overrun) begin
			wdt_q <= wdt_q + 12'h001;
		end
	end

	// Register decode
	wire hitCtrl = bus.addr == `ACR_OFF_CTRL;
	wire hitStatus = bus.addr == `ACR_OFF_STATUS;
	wire hitSel = bus.addr == `ACR_OFF_SEL;
	wire hitData = bus.addr == `ACR_OFF_DATA;

	logic [2:0] err_q;
	logic [8:0] chSel_q;
	wire [2:0] errSet = {overrun, alignBad, |pwShort};
	wire [2:0] errClr = (bus.wrEn & hitStatus) ? bus.wrData[`ACR_ST_ERR_HI:`ACR_ST_ERR_LO] : 3'h0;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `ACR_CTRL_RST;
			chSel_q <= 9'h000;
			err_q <= 3'h0;
		end else begin
			if (bus.wrEn && hitCtrl) begin
				ctrl_q <= bus.wrData[2:0];
			end
			if (bus.wrEn && hitSel) begin
				chSel_q <= bus.wrData[8:0];
			end
			// A new error in the clearing cycle survives
			err_q <= (err_q & ~errClr) | errSet;
		end
	end

	// Readback of one channel: total from the store, fine count from the counter
	wire [4:0] rdGroup = chSel_q[8:4];
	wire [3:0] rdChan = chSel_q[3:0];
	wire [3:0] rdPos = 4'hF - (rdChan - chanIdx_q);
	wire chValid = chSel_q < 9'(NCH);
	wire [7:0] rdAcc = chValid ? mem_q[rdGroup][rdPos] : 8'h00;
	wire [8:0] rdCnt = chValid ? cnt_q[chSel_q] : 9'h000;

	logic [31:0] statusWord;
	logic [31:0] dataWord;
	logic [31:0] rdMux;

	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[`ACR_ST_ERR_HI:`ACR_ST_ERR_LO] = err_q;
		statusWord[`ACR_ST_IDX_HI:`ACR_ST_IDX_LO] = chanIdx_q;
		statusWord[`ACR_ST_INTEG] = integrating;
		statusWord[`ACR_ST_SAMPC] = sampleDelayC_q[1];
		dataWord = 32'h0000_0000;
		dataWord[`ACR_DAT_ACC_HI:`ACR_DAT_ACC_LO] = rdAcc;
		dataWord[`ACR_DAT_CNT_HI:`ACR_DAT_CNT_LO] = rdCnt;
		rdMux = 32'h0000_0000;
		if (hitCtrl) begin
			rdMux = {29'h0, ctrl_q};
		end else if (hitStatus) begin
			rdMux = statusWord;
		end else if (hitSel) begin
			rdMux = {23'h0, chSel_q};
		end else if (hitData) begin
			rdMux = dataWord;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData_q <= 32'h0000_0000;
		end else if (bus.rdEn) begin
			rdData_q <= rdMux;
		end else begin
			rdData_q <= 32'h0000_0000;
		end
	end

endmodule // acr_channel_pipeline

`default_nettype wire

/* File: design/acr_defines.svh */
// Register offsets, field positions, reset values and timing counts for the channel pipeline
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

// Array geometry
`define ACR_CHANNELS 416
`define ACR_GROUPS 26
`define ACR_GROUP_SIZE 16
`define ACR_HALF 208
`define ACR_VF_FIRST 413
`define ACR_CNT_W 9
`define ACR_ACC_W 8

// Register bus
`define ACR_ADDR_W 8
`define ACR_DATA_W 32
`define ACR_OFF_CTRL 8'h00
`define ACR_OFF_STATUS 8'h04
`define ACR_OFF_SEL 8'h08
`define ACR_OFF_DATA 8'h0C

// Control register fields and reset value
`define ACR_CTRL_SERIAL 0
`define ACR_CTRL_TESTSEL 1
`define ACR_CTRL_TESTLVL 2
`define ACR_CTRL_RST 3'h3

// Status register fields
`define ACR_ST_ERR_LO 0
`define ACR_ST_ERR_HI 2
`define ACR_ST_IDX_LO 4
`define ACR_ST_IDX_HI 7
`define ACR_ST_INTEG 8
`define ACR_ST_SAMPC 9

// Data register fields
`define ACR_DAT_ACC_LO 0
`define ACR_DAT_ACC_HI 7
`define ACR_DAT_CNT_LO 8
`define ACR_DAT_CNT_HI 16

// Timing, clock period in ns
`define ACR_CLK_NS 5
`define ACR_T_CLEAR_NS 100
`define ACR_T_SELECT_NS 250
`define ACR_T_COUNT_NS 100
`define ACR_T_STORE_NS 100
`define ACR_T_SLOT_NS 750
`define ACR_T_SERVICE_NS 12800
`define ACR_CLEAR_CYC ((`ACR_T_CLEAR_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_SELECT_CYC ((`ACR_T_SELECT_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_COUNT_CYC ((`ACR_T_COUNT_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_STORE_CYC ((`ACR_T_STORE_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_SLOT_CYC (`ACR_T_SLOT_NS / `ACR_CLK_NS)
`define ACR_SERVICE_CYC (`ACR_T_SERVICE_NS / `ACR_CLK_NS)
`define ACR_WDT_W 12
`define ACR_PW_W 8

`endif

/* File: design/acr_pkg.sv */
// Types shared by the channel pipeline and its bench
package acr_pkg;

	// Strobes and levels from the control timing unit, all on clk
	typedef struct packed {
		logic sampleTick;
		logic integrateNotBlank;
		logic outLatchClear_n;
		logic [15:0] channelSelect;
		logic loadStrobeA_n;
		logic loadStrobeB_n;
		logic countStrobe;
		logic storeShiftStrobe;
		logic memoryClearCtl;
		logic resetGuard_n;
	} acr_ctl_s;

	// Raw sampler and converter pins
	typedef struct packed {
		logic samplerA;
		logic samplerB;
		logic samplerC;
		logic [2:0] vfPulse;
	} acr_pins_s;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wrData;
		logic wrEn;
		logic rdEn;
	} acr_bus_s;

endpackage
